// ===== src/rstseq_pkg.sv
/*
 reset sequencer package: register map, field layout, reset values and counts.
 assumes a 32-bit APB master on the same 40 MHz clock.
*/
package rstseq_pkg;
   localparam logic [11:0] CTRL_OFFSET = 12'h0_000;
   localparam logic [11:0] STAT_OFFSET = 12'h0_004;
   localparam logic [11:0] CORE_OFFSET = 12'h0_008;
   localparam logic [11:0] PC_OFFSET = 12'h0_00C;
   localparam int CTRL_SLOW_BIT = 0;
   localparam int CTRL_HOLD_BIT = 1;
   localparam int CTRL_RUN_BIT = 2;
   localparam int STAT_RESET_BIT = 0;
   localparam int STAT_HOLD_BIT = 1;
   localparam int STAT_SLOW_BIT = 2;
   localparam int STAT_PIN_BIT = 3;
   localparam int STAT_STATE_LSB = 4;
   localparam int CORE_SKIP_BIT = 0;
   localparam int CORE_BANK_BIT = 1;
   localparam int CORE_MIE_BIT = 2;
   localparam int CORE_MASK_LSB = 4;
   localparam int CORE_LATCH_LSB = 8;
   localparam int CORE_TIMER_LSB = 16;
   localparam logic [12:0] PC_RESET = 13'h0_000;
   localparam logic SKIP_RESET = 1'b1;
   localparam logic BANK_RESET = 1'b0;
   localparam logic MIE_RESET = 1'b0;
   localparam logic [3:0] MASK_RESET = 4'h0;
   localparam logic [3:0] LATCH_RESET = 4'h0;
   localparam logic [15:0] TIMER_RESET = 16'h0_000;
   localparam int RESET_MIN_CYCLES = 3;
   localparam int SLOW_DIV = 16;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   typedef enum logic [1:0] {RS_RUN = 2'b00, RS_RESET = 2'b01, RS_HOLD = 2'b10} rstseq_state_t;
   typedef struct packed {
      logic [12:0] pc;
      logic skipStatusFlag;
      logic dataBankSelect;
      logic irqMasterEnable;
      logic [3:0] irqEnableMask;
      logic [3:0] irqPendingLatch;
      logic [15:0] intervalTimer;
   } rstseq_core_t;
endpackage : rstseq_pkg

// ===== src/rstseq_filter.sv
/*
 pin synchroniser and low-level counter for the reset pin.
 assumes the pin is asynchronous to clk.
*/
`timescale 1ns/100ps
module rstseq_filter (
   input wire logic clk,
   input wire logic srst,
   input wire logic pinN,
   output logic pinSync,
   output logic lowQualified
);
   import rstseq_pkg::*;
   logic meta;
   logic [1:0] lowCount;
   always_ff @(posedge clk) begin
      if (srst) begin
         meta <= 1'b1;
         pinSync <= 1'b1;
      end else begin
         meta <= pinN;
         pinSync <= meta;
      end
   end
   // saturating count; glitches shorter than the minimum never qualify
   always_ff @(posedge clk) begin
      if (srst || pinSync) begin
         lowCount <= 2'd0;
      end else if (lowCount != 2'(RESET_MIN_CYCLES)) begin
         lowCount <= lowCount + 2'd1;
      end
   end
   assign lowQualified = (lowCount == 2'(RESET_MIN_CYCLES));
endmodule : rstseq_filter

// ===== src/rstseq_top.sv
/*
 reset sequencer for a small 4-bit core: pin qualification, core state
 initialisation, standby release, slow clock select, APB registers.
 assumes a 40 MHz clk, APB master on clk, reset pin asynchronous.
*/
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/100ps
// Operation
// - reset pin held low three or more cycles triggers a full reset.
// - on pin release execution starts at address zero.
// - reset loads program counter zero, skip flag one, interval timer zero.
// - reset clears the data bank select bit.
// - reset clears irq master enable, enable mask and pending latches.
// - no hardware keeps data memory across reset.
// - slow mode runs system logic from the low-frequency clock.
// - a low reset pin ends standby hold, reset follows at once.
module rstseq_top (
   input wire logic clk,
   input wire logic srst,
   input wire logic resetPinN,
   input wire logic slowTick,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic coreReset,
   output logic coreClkEn,
   output logic inHold,
   output rstseq_pkg::rstseq_core_t coreState
);
   import rstseq_pkg::*;
   ////////////////////////////////////////////////////////////////////////
   logic pinSync;
   logic lowQualified;
   rstseq_state_t state;
   logic [31:0] ctrl;
   logic slowSync1;
   logic slowSync2;
   logic slowPrev;
   logic apbWrite;
   rstseq_filter u_filter (
      .clk(clk),
      .srst(srst),
      .pinN(resetPinN),
      .pinSync(pinSync),
      .lowQualified(lowQualified)
   );
   assign apbWrite = psel && penable && pwrite;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   ////////////////////////////////////////////////////////////////////////
   // sequencing
   always_ff @(posedge clk) begin
      if (srst) begin
         state <= RS_RESET;
      end else begin
         case (state)
            RS_RUN: begin
               if (lowQualified) begin
                  state <= RS_RESET;
               end else if (ctrl[CTRL_HOLD_BIT]) begin
                  state <= RS_HOLD;
               end
            end
            RS_RESET: begin
               if (pinSync) begin
                  state <= RS_RUN;
               end
            end
            RS_HOLD: begin
               // any low sample ends standby, not only a qualified one
               if (!pinSync) begin
                  state <= RS_RESET;
               end else if (!ctrl[CTRL_HOLD_BIT]) begin
                  state <= RS_RUN;
               end
            end
            default: state <= RS_RESET;
         endcase
      end
   end
   assign coreReset = (state == RS_RESET);
   assign inHold = (state == RS_HOLD);
   ////////////////////////////////////////////////////////////////////////
   // control register; the run bit is written by the core, which is modelled here via APB
   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl <= CTRL_RESET;
      end else if (state == RS_RESET) begin
         ctrl[CTRL_HOLD_BIT] <= 1'b0;
      end else if (apbWrite && paddr == CTRL_OFFSET) begin
         ctrl <= {29'h0000_0000, pwdata[2:0]};
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // slow clock select: low-frequency tick enables the core
   always_ff @(posedge clk) begin
      if (srst) begin
         slowSync1 <= 1'b0;
         slowSync2 <= 1'b0;
         slowPrev <= 1'b0;
      end else begin
         slowSync1 <= slowTick;
         slowSync2 <= slowSync1;
         slowPrev <= slowSync2;
      end
   end
   always_comb begin
      if (state != RS_RUN) begin
         coreClkEn = 1'b0;
      end else if (ctrl[CTRL_SLOW_BIT]) begin
         coreClkEn = slowSync2 && !slowPrev;
      end else begin
         coreClkEn = 1'b1;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // core state: reset values, then pc and timer advance while running
   always_ff @(posedge clk) begin
      if (srst || state == RS_RESET) begin
         coreState.pc <= PC_RESET;
         coreState.skipStatusFlag <= SKIP_RESET;
         coreState.intervalTimer <= TIMER_RESET;
         coreState.dataBankSelect <= BANK_RESET;
         coreState.irqMasterEnable <= MIE_RESET;
         coreState.irqEnableMask <= MASK_RESET;
         coreState.irqPendingLatch <= LATCH_RESET;
      end else begin
         if (state == RS_HOLD) begin
            coreState.intervalTimer <= TIMER_RESET;
         end else if (coreClkEn) begin
            coreState.intervalTimer <= coreState.intervalTimer + 16'h0_001;
            if (ctrl[CTRL_RUN_BIT]) begin
               coreState.pc <= coreState.pc + 13'h0_001;
            end
         end
         if (apbWrite && paddr == CORE_OFFSET) begin
            coreState.skipStatusFlag <= pwdata[CORE_SKIP_BIT];
            coreState.dataBankSelect <= pwdata[CORE_BANK_BIT];
            coreState.irqMasterEnable <= pwdata[CORE_MIE_BIT];
            coreState.irqEnableMask <= pwdata[CORE_MASK_LSB +: 4];
            coreState.irqPendingLatch <= pwdata[CORE_LATCH_LSB +: 4];
         end
      end
   end
   // data memory is not part of this block: only the ctrl slow and run bits survive a pin reset here
   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk) begin
      if (srst) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            CTRL_OFFSET: prdata <= ctrl;
            STAT_OFFSET: prdata <= {26'h000_0000, state, !pinSync, ctrl[CTRL_SLOW_BIT],
                                    inHold, coreReset};
            CORE_OFFSET: prdata <= {coreState.intervalTimer, 4'h0, coreState.irqPendingLatch,
                                    coreState.irqEnableMask, 1'b0, coreState.irqMasterEnable,
                                    coreState.dataBankSelect, coreState.skipStatusFlag};
            PC_OFFSET: prdata <= {19'h0_0000, coreState.pc};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////
   logic [2:0] lowRun;
   always_ff @(posedge clk) begin
      if (srst || pinSync) begin
         lowRun <= 3'd0;
      end else if (lowRun != 3'd7) begin
         lowRun <= lowRun + 3'd1;
      end
   end
   a_short_glitch: assert property (@(posedge clk) disable iff (srst)
      (state == RS_RUN && lowRun < 3'd2) |=> state != RS_RESET) else $error("reset on short glitch");
   a_long_low: assert property (@(posedge clk) disable iff (srst)
      (state == RS_RUN && lowRun == 3'd3) |=> state == RS_RESET) else $error("qualified low ignored");
   a_pc_zero: assert property (@(posedge clk) disable iff (srst)
      $fell(coreReset) |-> coreState.pc == 13'h0_000) else $error("pc not zero at release");
   a_skip_timer: assert property (@(posedge clk) disable iff (srst)
      coreReset ##1 coreReset |-> coreState.skipStatusFlag && coreState.intervalTimer == 16'h0_000)
      else $error("skip or timer wrong in reset");
   a_bank_clear: assert property (@(posedge clk) disable iff (srst)
      coreReset ##1 coreReset |-> !coreState.dataBankSelect) else $error("bank not cleared");
   a_irq_clear: assert property (@(posedge clk) disable iff (srst)
      coreReset ##1 coreReset |-> !coreState.irqMasterEnable && coreState.irqEnableMask == 4'h0
      && coreState.irqPendingLatch == 4'h0) else $error("irq state not cleared");
   a_slow_gate: assert property (@(posedge clk) disable iff (srst)
      (ctrl[CTRL_SLOW_BIT] && coreClkEn) |-> $rose(slowSync2)) else $error("slow mode ran fast");
   a_hold_exit: assert property (@(posedge clk) disable iff (srst)
      (inHold && !pinSync) |=> coreReset) else $error("hold not ended by pin");
endmodule : rstseq_top

// ===== verif/rstseq_reset_src.sv
/*
 reset source model: drives the reset pin and a free-running slow oscillator.
 assumes a pull-up holds the pin high whenever the model is not pulling it.
*/
`timescale 1ns/100ps
module rstseq_reset_src (
   input wire logic clk,
   input wire logic start,
   input wire logic [7:0] lowCycles,
   output logic pinN,
   output logic slowTick
);
   logic [7:0] left = 8'h00;
   logic [3:0] div = 4'h0;
   // pin low for exactly lowCycles clocks, then back to the pull-up level
   always_ff @(posedge clk) begin
      if (start) begin
         left <= lowCycles;
      end else if (left != 8'h00) begin
         left <= left - 8'h01;
      end
   end
   assign pinN = (left == 8'h00);
   // slow oscillator runs free, one rising edge every 16 clocks
   always_ff @(posedge clk) begin
      div <= div + 4'h1;
   end
   assign slowTick = div[3];
endmodule : rstseq_reset_src

// ===== verif/rstseq_tb_top.sv
/*
 testbench for the reset sequencer: pin reset, glitch, slow mode, hold exit.
 assumes the reset source model and zero-wait APB.
*/
`timescale 1ns/100ps
module rstseq_tb_top;
   import rstseq_pkg::*;
   logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, start = 0;
   logic [11:0] paddr = 12'h0_000;
   logic [31:0] pwdata = 32'h0000_0000, rd, w, prdata;
   logic [7:0] lowCycles = 8'h00;
   logic pinN, slowTick, pready, pslverr, coreReset, coreClkEn, inHold;
   rstseq_core_t coreState;
   int fails = 0, nCompared = 0, seed = 84929, n;
   rstseq_reset_src src (.clk(clk), .start(start), .lowCycles(lowCycles), .pinN(pinN), .slowTick(slowTick));
   rstseq_top uut (.clk(clk), .srst(srst), .resetPinN(pinN), .slowTick(slowTick), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .coreReset(coreReset), .coreClkEn(coreClkEn),
      .inHold(inHold), .coreState(coreState));
   initial forever #12.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////
   task check(input logic [39:0] seen, input logic [39:0] exp);
      nCompared++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task complete_run;
      if (fails == 0 && nCompared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : complete_run
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
      // start just after a rising edge; also keeps two transfers apart by one edge
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task pinLow(input int k);
      @(posedge clk);
      lowCycles <= k[7:0];
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
   endtask : pinLow
   task waitReset(input logic lvl);
      // sampled on the falling edge, where the state register has settled
      n = 0;
      @(negedge clk);
      while (coreReset !== lvl && n < 40) begin
         @(negedge clk);
         n++;
      end
      check(40'(coreReset), 40'(lvl));
   endtask : waitReset
   function automatic rstseq_core_t resetCore();
      return '{pc: PC_RESET, skipStatusFlag: SKIP_RESET, dataBankSelect: BANK_RESET,
         irqMasterEnable: MIE_RESET, irqEnableMask: MASK_RESET, irqPendingLatch: LATCH_RESET,
         intervalTimer: TIMER_RESET};
   endfunction : resetCore
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      check(coreState, resetCore());
      waitReset(1'b0);
      check(40'(coreState.pc), 40'(PC_RESET));
      // bank and master enable forced high so the next reset has something to clear
      w = $random(seed) | 32'h0000_0006;
      apb(1'b1, CORE_OFFSET, w, rd);
      apb(1'b0, CORE_OFFSET, 32'h0000_0000, rd);
      check(40'(rd[11:0]), 40'(w[11:0] & 12'hff7));
      apb(1'b1, CTRL_OFFSET, 32'h0000_0004, rd);
      // a glitch shorter than the minimum must not reset the core
      pinLow(1 + ($unsigned($random(seed)) % 2));
      n = 0;
      repeat (10) begin
         @(negedge clk);
         if (coreReset !== 1'b0) n++;
      end
      check(40'(n), 40'h0);
      // held past the minimum so that reset lasts several cycles
      pinLow(RESET_MIN_CYCLES + 2 + ($unsigned($random(seed)) % 2));
      waitReset(1'b1);
      @(negedge clk);
      check(coreState, resetCore());
      waitReset(1'b0);
      check(40'(coreState.pc), 40'(PC_RESET));
      apb(1'b0, CORE_OFFSET, 32'h0000_0000, rd);
      check(40'(rd[11:0]), 40'h001);
      apb(1'b1, CTRL_OFFSET, 32'h0000_0001, rd);
      n = 0;
      repeat (64) begin
         @(negedge clk);
         n += int'(coreClkEn);
      end
      check(40'(n), 40'(64 / SLOW_DIV));
      apb(1'b0, STAT_OFFSET, 32'h0000_0000, rd);
      check(40'(rd[STAT_SLOW_BIT]), 40'h1);
      apb(1'b1, CTRL_OFFSET, 32'h0000_0002, rd);
      // control lands at the access edge, the state one edge later
      repeat (2) @(negedge clk);
      check(40'(inHold), 40'h1);
      pinLow(1);
      waitReset(1'b1);
      check(40'(inHold), 40'h0);
      // exactly the minimum low time must still reset
      pinLow(RESET_MIN_CYCLES);
      waitReset(1'b1);
      apb(1'b0, 12'h0_010, 32'h0000_0000, rd);
      check(40'(rd), 40'h0);
      complete_run();
   end
   initial begin
      #(25 * 4000);
      fails++;
      complete_run();
   end
endmodule : rstseq_tb_top
